// ===== rtl/pssa_regs.sv
// Shadowed miscellaneous control register and auxiliary status summary.
// Assumes a management register port on sys_clk and status from PHY logic
// on the same clock; no synchronisers are needed on those inputs.
`timescale 1ns/1ns

// Summary of operation
// - Write with bit 15 set updates 14:11, 9, 4 and 3
// - Write with bit 15 clear updates 14:12
// - Bits 14:12 choose the 18h read view
// - Selector decodes power, test, control, normal
// - Bit 11 picks receive or transmit counting
// - Bit 9 keeps crossover without negotiation
// - Bit 4 enables wire-speed, resets to one
// - Bit 3 accepts writes to address zero
// - Write data bits 2:0 pick shadow register
// - Bit 15 shows negotiation complete
// - Bits 14:11 latch negotiation state entries
// - Three-bit speed and duplex encoding
// - Negotiated or manual mode by enable
// - Parallel detection fault latches until read
// - Remote fault follows link partner
// - New page received latches until read
// - Partner negotiation ability reported
// - Partner next-page ability reported
// - Link status up or down
// - Pause resolution receive and transmit
module pssa_regs (
  input  wire logic       sys_clk,        // System clock, 125 MHz
  input  wire logic       reset_n,        // Synchronous reset, active low
  // Register port
  input  wire logic [7:0] reg_addr,       // Register offset
  input  wire logic       reg_wr,         // Write strobe
  input  wire logic       reg_rd,         // Read strobe
  input  wire logic [15:0] reg_wdata,     // Write data
  output logic      [15:0] reg_rdata,     // Read data
  output logic            reg_rvalid,     // Read data valid
  // MDIO address filter
  input  wire logic [4:0] mdio_phy_addr,  // Address of current frame
  input  wire logic [4:0] own_phy_addr,   // This port's address
  output logic            mdio_wr_accept, // Accept the write
  // Control outputs
  output logic      [2:0] read_shadow_sel, // View for the 18h read
  output logic            sel_normal,     // Normal view
  output logic            sel_power,      // Power control view
  output logic            sel_test,       // Test register view
  output logic            sel_misc,       // Misc control view
  output logic            pkt_count_rx,   // Count received packets
  output logic            auto_mdix_force, // Crossover with forced mode
  output logic            wirespeed_en,   // Wire-speed feature on
  output logic            mdio_all_phy,   // Broadcast accept on
  // Status inputs
  input  wire logic       an_enable,      // Negotiation enabled
  input  wire logic       an_complete,    // Negotiation done
  input  wire logic [3:0] an_state_enter, // Pulses: good, ack, ability, np
  input  wire logic [2:0] best_shared_mode, // Negotiated mode
  input  wire logic [2:0] manual_mode,    // Forced mode
  input  wire logic       pd_fault,       // Parallel fault pulse
  input  wire logic       remote_fault,   // Partner remote fault
  input  wire logic       page_rx,        // New page pulse
  input  wire logic       lp_an_able,     // Partner negotiates
  input  wire logic       lp_np_able,     // Partner next page
  input  wire logic       link_up,        // Link good
  input  wire logic       pause_rx,       // Pause receive resolved
  input  wire logic       pause_tx        // Pause transmit resolved
);

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  logic misc_wr;  // Write aimed at the control shadow
  logic misc_rd;  // Read of the shared address
  logic stat_rd;  // Read of the status summary

  // Writes for other shadows belong to other registers
  always_comb begin
    misc_wr = reg_wr && (reg_addr == pssa_pkg::ADDR_MISC_CTRL)
              && (reg_wdata[2:0] == pssa_pkg::SHADOW_MISC);
    misc_rd = reg_rd && (reg_addr == pssa_pkg::ADDR_MISC_CTRL);
    stat_rd = reg_rd && (reg_addr == pssa_pkg::ADDR_AUX_STATUS);
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  logic [2:0] shadow_ptr;       // Last shadow code written
  logic [2:0] next_shadow_ptr;
  logic [2:0] next_read_shadow_sel;
  logic       next_pkt_count_rx;
  logic       next_auto_mdix_force;
  logic       next_wirespeed_en;
  logic       next_mdio_all_phy;

  // Gate bit decides the span; it is never stored, so it self-clears
  always_comb begin
    next_shadow_ptr      = shadow_ptr;
    next_read_shadow_sel = read_shadow_sel;
    next_pkt_count_rx    = pkt_count_rx;
    next_auto_mdix_force = auto_mdix_force;
    next_wirespeed_en    = wirespeed_en;
    next_mdio_all_phy    = mdio_all_phy;
    if (reg_wr && (reg_addr == pssa_pkg::ADDR_MISC_CTRL)) begin
      next_shadow_ptr = reg_wdata[2:0];
    end
    if (misc_wr) begin
      // Selector is written either way
      next_read_shadow_sel =
        reg_wdata[pssa_pkg::BIT_RDSEL_HI:pssa_pkg::BIT_RDSEL_LO];
      if (reg_wdata[pssa_pkg::BIT_WRITE_EN]) begin
        next_pkt_count_rx    = reg_wdata[pssa_pkg::BIT_PKT_RX];
        next_auto_mdix_force = reg_wdata[pssa_pkg::BIT_MDIX];
        next_wirespeed_en    = reg_wdata[pssa_pkg::BIT_WSPEED];
        next_mdio_all_phy    = reg_wdata[pssa_pkg::BIT_ALL_PHY];
      end
    end
  end

  // Control register stage
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      shadow_ptr      <= pssa_pkg::RST_SHADOW;
      read_shadow_sel <= pssa_pkg::RST_RDSEL;
      pkt_count_rx    <= pssa_pkg::RST_PKT_RX;
      auto_mdix_force <= pssa_pkg::RST_MDIX;
      wirespeed_en    <= pssa_pkg::RST_WSPEED;
      mdio_all_phy    <= pssa_pkg::RST_ALL_PHY;
    end else begin
      shadow_ptr      <= next_shadow_ptr;
      read_shadow_sel <= next_read_shadow_sel;
      pkt_count_rx    <= next_pkt_count_rx;
      auto_mdix_force <= next_auto_mdix_force;
      wirespeed_en    <= next_wirespeed_en;
      mdio_all_phy    <= next_mdio_all_phy;
    end
  end

  // ----------------------------------------------------------------
  // Selector decode and write filter
  // ----------------------------------------------------------------
  // Unlisted selector codes select nothing; the 18h mux keeps normal data
  always_comb begin
    sel_normal = (read_shadow_sel == pssa_pkg::RDSEL_NORMAL);
    sel_power  = (read_shadow_sel == pssa_pkg::SHADOW_POWER);
    sel_test   = (read_shadow_sel == pssa_pkg::SHADOW_TEST);
    sel_misc   = (read_shadow_sel == pssa_pkg::SHADOW_MISC);
    mdio_wr_accept = (mdio_phy_addr == own_phy_addr)
                     || (mdio_all_phy && (mdio_phy_addr == pssa_pkg::BCAST_PHY));
  end

  // ----------------------------------------------------------------
  // Status sources
  // ----------------------------------------------------------------
  logic [pssa_pkg::NUM_LATCHED-1:0] lh_set;  // Latched-high events
  logic [pssa_pkg::NUM_LATCHED-1:0] lh_q;    // latched_high flags
  logic [2:0]                       speed_code; // Reported mode

  // Order: four state entries, parallel fault, page received
  always_comb begin
    lh_set = {an_state_enter, pd_fault, page_rx};
  end

  // Flags clear on status read; a new event in that cycle wins
  pssa_latch_bits #(
    .N         (pssa_pkg::NUM_LATCHED)
  ) u_latch (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .set_pulse (lh_set),
    .clear     (stat_rd),
    .q         (lh_q)
  );

  // Negotiated or manual mode
  pssa_speed_mux u_speed (
    .sys_clk          (sys_clk),
    .reset_n          (reset_n),
    .an_enable        (an_enable),
    .an_complete      (an_complete),
    .best_shared_mode (best_shared_mode),
    .manual_mode      (manual_mode),
    .speed_code       (speed_code)
  );

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [15:0] misc_word;   // Control view, reserved bits zero
  logic [15:0] stat_word;   // Status view
  logic [15:0] next_rdata;
  logic        next_rvalid;

  // Assemble the two read views
  always_comb begin
    misc_word = 16'h0000;
    misc_word[pssa_pkg::BIT_RDSEL_HI:pssa_pkg::BIT_RDSEL_LO] = read_shadow_sel;
    misc_word[pssa_pkg::BIT_PKT_RX]  = pkt_count_rx;
    misc_word[pssa_pkg::BIT_MDIX]    = auto_mdix_force;
    misc_word[pssa_pkg::BIT_WSPEED]  = wirespeed_en;
    misc_word[pssa_pkg::BIT_ALL_PHY] = mdio_all_phy;
    misc_word[2:0]                   = pssa_pkg::SHADOW_MISC;
    stat_word = 16'h0000;
    stat_word[pssa_pkg::ST_AN_DONE]    = an_complete;
    stat_word[14:11]                   = lh_q[5:2];
    stat_word[10:8]                    = speed_code;
    stat_word[pssa_pkg::ST_PD_FAULT]   = lh_q[1];
    stat_word[pssa_pkg::ST_REM_FAULT]  = remote_fault;
    stat_word[pssa_pkg::ST_PAGE_RX]    = lh_q[0];
    stat_word[pssa_pkg::ST_LP_AN]      = lp_an_able;
    stat_word[pssa_pkg::ST_LP_NP]      = lp_np_able;
    stat_word[pssa_pkg::ST_LINK]       = link_up;
    stat_word[pssa_pkg::ST_PAUSE_RX]   = pause_rx;
    stat_word[pssa_pkg::ST_PAUSE_TX]   = pause_tx;
  end

  // Other shadows at the shared address live elsewhere and read zero here
  always_comb begin
    next_rvalid = reg_rd;
    next_rdata  = 16'h0000;
    if (misc_rd && (shadow_ptr == pssa_pkg::SHADOW_MISC)) begin
      next_rdata = misc_word;
    end else if (stat_rd) begin
      next_rdata = stat_word;
    end
  end

  // Read data register; it holds until the next read
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= next_rvalid;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_full_write;
    misc_wr && reg_wdata[pssa_pkg::BIT_WRITE_EN];
  endsequence

  sequence s_part_write;
    misc_wr && !reg_wdata[pssa_pkg::BIT_WRITE_EN];
  endsequence

  sequence s_fault_then_quiet;
    pd_fault ##1 (!stat_rd)[*3];
  endsequence

  AST_FULL_WRITE: assert property (
    s_full_write |=> (wirespeed_en == $past(reg_wdata[4]))
                     && (pkt_count_rx == $past(reg_wdata[11]))
                     && (mdio_all_phy == $past(reg_wdata[3])))
    else $error("Full write did not update control bits");

  AST_PART_WRITE: assert property (
    s_part_write |=> $stable(wirespeed_en) && $stable(pkt_count_rx)
                     && $stable(auto_mdix_force) && $stable(mdio_all_phy)
                     && (read_shadow_sel == $past(reg_wdata[14:12])))
    else $error("Partial write touched protected bits");

  AST_SELF_CLEAR: assert property (
    misc_wr ##1 (reg_rd && reg_addr == pssa_pkg::ADDR_MISC_CTRL)
      |=> reg_rvalid && !reg_rdata[15] && (reg_rdata[2:0] == 3'h7))
    else $error("Write gate bit did not read back clear");

  AST_SEL_DECODE: assert property (
    (sel_power == (read_shadow_sel == 3'h2)) && (sel_test == (read_shadow_sel == 3'h4))
    && (sel_misc == (read_shadow_sel == 3'h7)) && (sel_normal == (read_shadow_sel == 3'h0)))
    else $error("Read selector decode wrong");

  AST_ALL_PHY: assert property (
    (mdio_phy_addr == 5'h00) && (own_phy_addr != 5'h00) |-> mdio_wr_accept == mdio_all_phy)
    else $error("Broadcast write acceptance wrong");

  AST_FAULT_HOLD: assert property (
    s_fault_then_quiet |-> lh_q[1])
    else $error("Parallel fault flag dropped before read");

  AST_CLEAR_READ: assert property (
    stat_rd && (lh_set == '0) |=> (lh_q == '0))
    else $error("Latched flags not cleared by read");

  AST_SET_WINS: assert property (
    stat_rd && page_rx |=> lh_q[0] ##1 1'b1)
    else $error("Page event lost during clearing read");

  AST_STATUS_LIVE: assert property (
    stat_rd |=> reg_rvalid && (reg_rdata[2] == $past(link_up))
               && (reg_rdata[15] == $past(an_complete)) && (reg_rdata[6] == $past(remote_fault)))
    else $error("Live status bits misreported");

  AST_SPEED_MANUAL: assert property (
    !an_enable [*2] |-> speed_code == $past(manual_mode))
    else $error("Manual mode not reported");

endmodule : pssa_regs

// ===== rtl/pssa_pkg.sv
// Constants for the PHY shadow control and auxiliary status register pair.
// Assumes a single management clock domain and 16-bit management registers.
package pssa_pkg;

  // ----------------------------------------------------------------
  // Register offsets and shadow codes
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_MISC_CTRL  = 8'h30;  // Shared shadowed address
  localparam logic [7:0]  ADDR_AUX_STATUS = 8'h32;  // Status summary
  localparam logic [2:0]  SHADOW_AUX_CTRL = 3'h0;   // Auxiliary control
  localparam logic [2:0]  SHADOW_10BT     = 3'h1;   // 10BASE-T
  localparam logic [2:0]  SHADOW_POWER    = 3'h2;   // Power/MII control
  localparam logic [2:0]  SHADOW_TEST     = 3'h4;   // Miscellaneous test
  localparam logic [2:0]  SHADOW_MISC     = 3'h7;   // Miscellaneous control
  localparam logic [2:0]  RDSEL_NORMAL    = 3'h0;   // Normal / 10BASE-T view

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int BIT_WRITE_EN  = 15;  // Self-clearing write gate
  localparam int BIT_RDSEL_HI  = 14;  // Read selector top
  localparam int BIT_RDSEL_LO  = 12;  // Read selector bottom
  localparam int BIT_PKT_RX    = 11;  // Packet counter direction
  localparam int BIT_MDIX      = 9;   // Forced auto-MDIX
  localparam int BIT_WSPEED    = 4;   // Wire-speed feature enable
  localparam int BIT_ALL_PHY   = 3;   // Broadcast write accept

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] RST_RDSEL     = 3'h0;
  localparam logic       RST_PKT_RX    = 1'b0;
  localparam logic       RST_MDIX      = 1'b0;
  localparam logic       RST_WSPEED    = 1'b1;
  localparam logic       RST_ALL_PHY   = 1'b0;
  localparam logic [2:0] RST_SHADOW    = 3'h0;  // Last written shadow code
  localparam logic [4:0] BCAST_PHY     = 5'h00; // Broadcast PHY address

  // ----------------------------------------------------------------
  // Status field positions
  // ----------------------------------------------------------------
  localparam int ST_AN_DONE   = 15;
  localparam int ST_SPEED_LO  = 8;   // Field is [10:8]
  localparam int ST_PD_FAULT  = 7;
  localparam int ST_REM_FAULT = 6;
  localparam int ST_PAGE_RX   = 5;
  localparam int ST_LP_AN     = 4;
  localparam int ST_LP_NP     = 3;
  localparam int ST_LINK      = 2;
  localparam int ST_PAUSE_RX  = 1;
  localparam int ST_PAUSE_TX  = 0;
  localparam int NUM_LATCHED  = 6;   // Four states, fault, page
  localparam logic [2:0] SPEED_NONE = 3'h0;

endpackage : pssa_pkg

// ===== rtl/pssa_latch_bits.sv
// Bank of latched-high event flags that clear on a management read.
// Assumes set pulses and the clear strobe come from the same clock.
`timescale 1ns/1ns

module pssa_latch_bits #(
  parameter int N = 6                  // Number of flags
) (
  input  wire logic         sys_clk,   // System clock
  input  wire logic         reset_n,   // Synchronous reset, active low
  input  wire logic [N-1:0] set_pulse, // Event pulses
  input  wire logic         clear,     // Read strobe
  output logic      [N-1:0] q          // Latched flags
);

  // ----------------------------------------------------------------
  // Per-flag next value
  // ----------------------------------------------------------------
  logic [N-1:0] next_q;  // Next flag state

  // A set in the clearing cycle survives, so no event is lost
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_bit
      always_comb begin
        next_q[gi] = set_pulse[gi] | (q[gi] & ~clear);
      end
    end
  endgenerate

  // Register stage
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

endmodule : pssa_latch_bits

// ===== rtl/pssa_speed_mux.sv
// Chooses the reported speed and duplex code.
// Assumes both codes and the enable come from the same clock domain.
`timescale 1ns/1ns

module pssa_speed_mux (
  input  wire logic       sys_clk,      // System clock
  input  wire logic       reset_n,      // Synchronous reset, active low
  input  wire logic       an_enable,    // Auto-negotiation enabled
  input  wire logic       an_complete,  // Negotiation finished
  input  wire logic [2:0] best_shared_mode, // Negotiated result
  input  wire logic [2:0] manual_mode,  // Manually forced mode
  output logic      [2:0] speed_code    // Registered report
);

  // ----------------------------------------------------------------
  // Selection
  // ----------------------------------------------------------------
  logic [2:0] next_speed_code;  // Next reported code

  // Incomplete negotiation reports no common mode
  always_comb begin
    if (!an_enable) begin
      next_speed_code = manual_mode;
    end else if (an_complete) begin
      next_speed_code = best_shared_mode;
    end else begin
      next_speed_code = pssa_pkg::SPEED_NONE;
    end
  end

  // Register stage
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      speed_code <= pssa_pkg::SPEED_NONE;
    end else begin
      speed_code <= next_speed_code;
    end
  end

endmodule : pssa_speed_mux

// ===== dv/pssa_station.sv
// Management station model that drives the register port of the block.
// Assumes one bench process calls its tasks; requests last one cycle.
`timescale 1ns/1ns

module pssa_station (
  input  wire logic        sys_clk,   // System clock
  output logic      [7:0]  reg_addr,  // Register offset
  output logic             reg_wr,    // Write strobe
  output logic             reg_rd,    // Read strobe
  output logic      [15:0] reg_wdata  // Write data
);
  logic [15:0] exp_q[$];  // Expected read data, oldest first

  // Port starts quiet so the first edges after reset see no stray strobe
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 16'h0000;
  end

  // ----------------------------------------------------------------
  // Request tasks
  // ----------------------------------------------------------------
  // One request per edge, launched 1 ns after it
  task automatic op(input logic w, input logic r, input logic [7:0] a,
                    input logic [15:0] d);
    @(posedge sys_clk);
    #1;
    reg_wr    = w;
    reg_rd    = r;
    reg_addr  = a;
    reg_wdata = d;
  endtask : op

  // Write; reserved control bits forced low
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    if (a == pssa_pkg::ADDR_MISC_CTRL && d[2:0] == pssa_pkg::SHADOW_MISC) begin
      d = d & 16'hfa1f;
    end
    op(1'b1, 1'b0, a, d);
  endtask : wr

  // Read; the expected word is noted first
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    op(1'b0, 1'b1, a, ~reg_wdata);
  endtask : rd

  // Release: lines flip so a stale value never looks valid
  task automatic idle();
    op(1'b0, 1'b0, ~reg_addr, ~reg_wdata);
  endtask : idle
endmodule : pssa_station

// ===== dv/pssa_regs_tb.sv
// Self-checking bench for the control shadow and status summary pair.
// Assumes the station model drives the register port; status from here.
`timescale 1ns/1ns

`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, e); end end

module pssa_regs_tb;
  logic        sys_clk, reset_n;                 // Clock and reset
  logic [7:0]  reg_addr;                          // Register port
  logic        reg_wr, reg_rd, reg_rvalid;
  logic [15:0] reg_wdata, reg_rdata;
  logic [4:0]  mdio_phy_addr, own_phy_addr;       // Address filter
  logic        mdio_wr_accept;
  logic [2:0]  read_shadow_sel;                   // Control outputs
  logic        sel_normal, sel_power, sel_test, sel_misc;
  logic        pkt_count_rx, auto_mdix_force, wirespeed_en, mdio_all_phy;
  logic        an_enable, an_complete, pd_fault, page_rx;  // Status
  logic [3:0]  an_state_enter;
  logic [2:0]  best_shared_mode, manual_mode;
  logic        remote_fault, lp_an_able, lp_np_able, link_up;
  logic        pause_rx, pause_tx;
  int          n_errors, checked;                 // Tallies
  logic [15:0] ctl, r, exp_v;                      // Control model, random, note
  logic [2:0]  s;                                  // Selector code
  logic [3:0]  ev;                                 // Event pulses
  logic        pd, pg;

  pssa_regs pssa_regs_i (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .mdio_phy_addr(mdio_phy_addr), .own_phy_addr(own_phy_addr),
    .mdio_wr_accept(mdio_wr_accept), .read_shadow_sel(read_shadow_sel),
    .sel_normal(sel_normal), .sel_power(sel_power), .sel_test(sel_test),
    .sel_misc(sel_misc), .pkt_count_rx(pkt_count_rx), .auto_mdix_force(auto_mdix_force),
    .wirespeed_en(wirespeed_en), .mdio_all_phy(mdio_all_phy), .an_enable(an_enable),
    .an_complete(an_complete), .an_state_enter(an_state_enter),
    .best_shared_mode(best_shared_mode), .manual_mode(manual_mode), .pd_fault(pd_fault),
    .remote_fault(remote_fault), .page_rx(page_rx), .lp_an_able(lp_an_able),
    .lp_np_able(lp_np_able), .link_up(link_up), .pause_rx(pause_rx), .pause_tx(pause_tx));

  pssa_station pssa_station_i (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata));

  // ----------------------------------------------------------------
  // Clock, watchdog and read monitor
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Hang guard: the whole run needs far fewer cycles
  initial begin
    repeat (4000) @(posedge sys_clk);
    n_errors++;
    give_verdict();
  end

  // Oldest note is compared whenever read data is flagged
  always @(posedge sys_clk) begin
    if (reg_rvalid === 1'b1) begin
      if (pssa_station_i.exp_q.size() == 0) begin
        n_errors++;
        $display("wrong value at %0t: got %h expected %h", $time, reg_rdata, 16'h0);
      end else begin
        // Pop once; the macro reads its expected value twice
        exp_v = pssa_station_i.exp_q.pop_front();
        `CHK(reg_rdata, exp_v)
      end
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Status word built from what this bench drives
  function automatic logic [15:0] stat(input logic [3:0] l, input logic f, input logic p);
    logic [2:0] sp;
    sp = an_enable ? (an_complete ? best_shared_mode : 3'h0) : manual_mode;
    return {an_complete, l, sp, f, remote_fault, p, lp_an_able, lp_np_able, link_up,
            pause_rx, pause_tx};
  endfunction : stat

  // Control outputs against the model
  task automatic chk_ctl();
    `CHK({read_shadow_sel, pkt_count_rx, auto_mdix_force, wirespeed_en, mdio_all_phy},
         {ctl[14:12], ctl[11], ctl[9], ctl[4], ctl[3]})
    `CHK({sel_normal, sel_power, sel_test, sel_misc},
         {ctl[14:12] == 3'h0, ctl[14:12] == 3'h2, ctl[14:12] == 3'h4, ctl[14:12] == 3'h7})
  endtask : chk_ctl

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    r = 16'($urandom(32));
    {reset_n, mdio_phy_addr, own_phy_addr, an_enable, an_complete, an_state_enter} = '0;
    {best_shared_mode, manual_mode, pd_fault, page_rx, remote_fault} = '0;
    {lp_an_able, lp_np_able, link_up, pause_rx, pause_tx} = '0;
    ctl = 16'h0010;
    repeat (6) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    // Reset view: pointer not yet 111, status empty
    chk_ctl();
    pssa_station_i.rd(8'h30, 16'h0000);
    pssa_station_i.rd(8'h32, 16'h0000);
    pssa_station_i.wr(8'h30, 16'h0007);
    pssa_station_i.rd(8'h30, 16'h0017);
    pssa_station_i.idle();
    $display("test reset done");
    // Full writes, then selector-only writes, back to back
    for (int i = 0; i < 8; i++) begin
      r = 16'($urandom);
      s = 3'(i);
      pssa_station_i.wr(8'h30, {1'b1, r[14:3], 3'h7});
      ctl = {1'b0, r[14:3], 3'h0} & 16'h7a18;
      pssa_station_i.wr(8'h30, {1'b0, s, ~r[11:3], 3'h7});
      ctl[14:12] = s;
      pssa_station_i.rd(8'h30, ctl | 16'h0007);
      pssa_station_i.idle();
      chk_ctl();
      repeat (4) begin
        @(posedge sys_clk);
        #1 mdio_phy_addr = ($urandom % 2) ? 5'h00 : 5'($urandom);
        own_phy_addr = 5'($urandom % 3);
        #1 `CHK(mdio_wr_accept, (mdio_phy_addr == own_phy_addr) || (ctl[3] && mdio_phy_addr == 5'h00))
      end
    end
    // Other shadow codes leave the control bits alone; hole reads zero
    pssa_station_i.wr(8'h30, 16'hfff9);
    pssa_station_i.rd(8'h30, 16'h0000);
    pssa_station_i.wr(8'h34, 16'hffff);
    pssa_station_i.rd(8'h34, 16'h0000);
    pssa_station_i.idle();
    chk_ctl();
    $display("test control done");
    // Status: every speed code, latched flags, clear on read
    for (int i = 0; i < 16; i++) begin
      r = 16'($urandom);
      {an_enable, an_complete, remote_fault, lp_an_able, lp_np_able} = r[4:0];
      {link_up, pause_rx, pause_tx} = r[7:5];
      best_shared_mode = 3'(i);
      manual_mode = 3'(i);
      {ev, pd, pg} = r[15:10];
      @(posedge sys_clk);
      #1 {an_state_enter, pd_fault, page_rx} = {ev, pd, pg};
      @(posedge sys_clk);
      #1 {an_state_enter, pd_fault, page_rx} = '0;
      repeat (2) @(posedge sys_clk);
      pssa_station_i.rd(8'h32, stat(ev, pd, pg));
      pssa_station_i.rd(8'h32, stat(4'h0, 1'b0, 1'b0));
      pssa_station_i.idle();
    end
    // Page event in the clearing read's cycle survives to the next read
    pssa_station_i.rd(8'h32, stat(4'h0, 1'b0, 1'b0));
    page_rx = 1'b1;
    pssa_station_i.rd(8'h32, stat(4'h0, 1'b0, 1'b1));
    page_rx = 1'b0;
    pssa_station_i.rd(8'h32, stat(4'h0, 1'b0, 1'b0));
    pssa_station_i.idle();
    $display("test status done");
    for (int k = 0; k < 10 && pssa_station_i.exp_q.size() != 0; k++) @(posedge sys_clk);
    if (pssa_station_i.exp_q.size() != 0) n_errors++;
    give_verdict();
  end
endmodule : pssa_regs_tb
